// *** core/dgs_pkg.sv ***
// Package for the processor-side DRAM access sequencer
package dgs_pkg;
   // Data-space windows decoded by the strobe glue
   localparam logic [13:0] ROW_BASE   = 14'h1000;
   localparam logic [13:0] CLEAR_BASE = 14'h2000;
   localparam logic [13:0] COL_BASE   = 14'h3000;
   localparam logic [13:0] INT_BOUND  = 14'h3800;
   localparam int          LINE_W     = 10;
   localparam int          ADDR_W     = 14;
   localparam int          DATA_W     = 16;
   // Wait states on the column window; column access held two cycles
   localparam logic [1:0]  COL_WAIT   = 2'h1;
   // Idle cycles after a closing access, for row precharge
   localparam logic [1:0]  PRE_IDLE   = 2'h1;

   typedef struct packed {
      logic              write;
      logic [LINE_W-1:0] row;
      logic [LINE_W-1:0] col;
      logic              page;   // Keep row open afterwards
      logic [DATA_W-1:0] wdata;
   } dgs_req_t;

   typedef struct packed {
      logic              dms_n;
      logic              rd_n;
      logic              wr_n;
      logic [ADDR_W-1:0] addr;
   } dgs_bus_t;

   typedef enum logic [1:0] {
      ACC_ROW,
      ACC_COL,
      ACC_CLEAR,
      ACC_IDLE
   } dgs_acc_t;
endpackage : dgs_pkg

// *** core/dgs_host.sv ***
// Processor-side sequencer that drives the DRAM strobe glue over the bus
module dgs_host
   import dgs_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // Request port
   input  wire logic              req_valid_i,
   input  dgs_req_t               req_i,
   output logic                   req_ready_o,
   output logic                   rsp_valid_o,
   output logic [DATA_W-1:0]      rsp_data_o,
   // Processor-style external bus
   output dgs_bus_t               bus_o,
   output logic [DATA_W-1:0]      data_o,
   output logic                   data_oe_o,
   input  wire logic [DATA_W-1:0] data_i,
   output logic [1:0]             data_wait_count_bank3_o
);

   function automatic logic [ADDR_W-1:0] win(input logic [13:0] base,
                                             input logic [LINE_W-1:0] a);
      win = base | {4'h0, a};
   endfunction : win

   dgs_acc_t         acc;
   dgs_req_t         cur;
   logic             busy;
   logic             row_open;
   logic [LINE_W-1:0] open_row;
   logic [1:0]       cnt;
   // Set once the column access is done, so the closing idle ends the job
   // instead of reopening a row for a request still pending after a miss
   logic             served;

   assign data_wait_count_bank3_o = COL_WAIT;
   assign req_ready_o = !busy;

   // Sequencer: row, column (held COL_WAIT+1 cycles), clear, idle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy     <= 1'b0;
         acc      <= ACC_IDLE;
         cnt      <= 2'h0;
         row_open <= 1'b0;
         open_row <= '0;
         cur      <= '0;
         served   <= 1'b0;
      end else if (!busy) begin
         if (req_valid_i) begin
            busy <= 1'b1;
            cur  <= req_i;
            served <= 1'b0;
            cnt  <= 2'h0;
            // Page hit skips the row access entirely
            if (row_open && open_row == req_i.row) begin
               acc <= ACC_COL;
            end else if (row_open) begin
               acc <= ACC_CLEAR;
            end else begin
               acc <= ACC_ROW;
            end
         end
      end else begin
         unique case (acc)
            ACC_ROW: begin
               acc      <= ACC_COL;
               row_open <= 1'b1;
               open_row <= cur.row;
            end
            ACC_COL: begin
               if (cnt == COL_WAIT) begin
                  cnt <= 2'h0;
                  served <= 1'b1;
                  if (cur.page) begin
                     busy <= 1'b0;
                     acc  <= ACC_IDLE;
                  end else begin
                     acc <= ACC_CLEAR;
                  end
               end else begin
                  cnt <= cnt + 2'h1;
               end
            end
            ACC_CLEAR: begin
               // Also taken first on a miss, so the old row is shut first
               row_open <= 1'b0;
               cnt      <= 2'h0;
               acc      <= ACC_IDLE;
            end
            ACC_IDLE: begin
               // Precharge gap; a pending miss resumes with its row
               if (cnt == PRE_IDLE - 2'h1) begin
                  cnt <= 2'h0;
                  if (served) begin
                     busy <= 1'b0;
                  end else begin
                     acc <= ACC_ROW;
                  end
               end else begin
                  cnt <= cnt + 2'h1;
               end
            end
         endcase
      end
   end

   // Bus drive: a row/clear access is a dummy read; column reads or writes
   always_comb begin
      bus_o     = '{dms_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: '0};
      data_oe_o = 1'b0;
      if (busy) begin
         unique case (acc)
            ACC_ROW: begin
               bus_o = '{1'b0, 1'b0, 1'b1, win(ROW_BASE, cur.row)};
            end
            ACC_COL: begin
               bus_o.dms_n = 1'b0;
               bus_o.addr  = win(COL_BASE, cur.col);
               bus_o.rd_n  = cur.write;
               bus_o.wr_n  = !cur.write;
               data_oe_o   = cur.write;
            end
            ACC_CLEAR: begin
               bus_o = '{1'b0, 1'b0, 1'b1, CLEAR_BASE};
            end
            ACC_IDLE: begin
               bus_o = '{1'b1, 1'b1, 1'b1, '0};
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_o      <= '0;
         rsp_valid_o <= 1'b0;
         rsp_data_o  <= '0;
      end else begin
         data_o      <= (!busy && req_valid_i) ? req_i.wdata : data_o;
         rsp_valid_o <= busy && acc == ACC_COL && cnt == COL_WAIT;
         if (busy && acc == ACC_COL && cnt == COL_WAIT && !cur.write) begin
            rsp_data_o <= data_i;
         end
      end
   end

   // Checks watch the bus and answer that this block drives
   AST_COL_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      (busy && acc == ACC_COL && cnt == 2'h0)
      |-> (!bus_o.dms_n && bus_o.addr[13:12] == 2'b11) [*2])
      else $error("column access shorter than two cycles");
   AST_ROW_ADDR: assert property (@(posedge clk_i) disable iff (rst_i)
      (busy && acc == ACC_ROW) |-> bus_o.addr[13:12] == 2'b01 && !bus_o.rd_n)
      else $error("row access not a row-window read");
   AST_NO_INT: assert property (@(posedge clk_i) disable iff (rst_i)
      !bus_o.dms_n |-> bus_o.addr < INT_BOUND)
      else $error("internal address on external bus");
   AST_READ_WR: assert property (@(posedge clk_i) disable iff (rst_i)
      (busy && acc == ACC_COL && !cur.write) |-> bus_o.wr_n)
      else $error("write strobe during read");
   AST_RST: assert property (@(posedge clk_i)
      $past(rst_i) |-> bus_o.dms_n && !rsp_valid_o)
      else $error("bus active after reset");
   AST_WAIT: assert property (@(posedge clk_i) disable iff (rst_i)
      data_wait_count_bank3_o == 2'h1)
      else $error("bank three wait count wrong");
   AST_GAP: assert property (@(posedge clk_i) disable iff (rst_i)
      (busy && acc == ACC_CLEAR) |=> bus_o.dms_n)
      else $error("no precharge gap after clear");
   AST_ORDER: assert property (@(posedge clk_i) disable iff (rst_i)
      (busy && acc == ACC_ROW) |=> !bus_o.dms_n && bus_o.addr[13:12] == 2'b11)
      else $error("column does not follow row");
   AST_CLOSE: assert property (@(posedge clk_i) disable iff (rst_i)
      (busy && acc == ACC_COL && cnt == COL_WAIT && !cur.page)
      |=> !bus_o.dms_n && !bus_o.rd_n && bus_o.wr_n
          && bus_o.addr == CLEAR_BASE)
      else $error("non-page access not closed by a clear read");
   AST_LINES: assert property (@(posedge clk_i) disable iff (rst_i)
      !bus_o.dms_n |-> bus_o.addr[11:10] == 2'h0)
      else $error("address bits above the low lines set");
   AST_WR_DATA: assert property (@(posedge clk_i) disable iff (rst_i)
      data_oe_o == !bus_o.wr_n
      && (bus_o.wr_n || bus_o.addr[13:12] == 2'b11))
      else $error("write data driven outside a column write");
   AST_PAGE: assert property (@(posedge clk_i) disable iff (rst_i)
      (busy && acc == ACC_COL && cnt == COL_WAIT && cur.page)
      |=> req_ready_o && bus_o.dms_n && row_open)
      else $error("page access did not leave its row open");

   COV_READ: cover property (@(posedge clk_i) disable iff (rst_i)
      busy && acc == ACC_COL && !cur.write);
   COV_WRITE: cover property (@(posedge clk_i) disable iff (rst_i)
      busy && acc == ACC_COL && cur.write);
   COV_PAGE: cover property (@(posedge clk_i) disable iff (rst_i)
      req_valid_i && req_ready_o && row_open && open_row == req_i.row);
   COV_MISS: cover property (@(posedge clk_i) disable iff (rst_i)
      req_valid_i && req_ready_o && row_open && open_row != req_i.row);
   COV_RESUME: cover property (@(posedge clk_i) disable iff (rst_i)
      busy && acc == ACC_IDLE && !served ##1 acc == ACC_ROW);
endmodule : dgs_host

// *** verification/dgs_dram_model.sv ***
// Behavioural strobe glue and small DRAM bank facing the sequencer
module dgs_dram_model
   import dgs_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // Processor side
   input  dgs_bus_t               bus_i,
   input  wire logic [DATA_W-1:0] data_i,
   output logic [DATA_W-1:0]      data_o,
   // DRAM strobes
   output logic                   row_strobe_n_o,
   output logic                   column_strobe_n_o,
   output logic                   store_strobe_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DATA_W-1:0] mem [0:63];
   logic [2:0]        row_q;
   logic [DATA_W-1:0] last;
   logic              sel;
   assign sel = !bus_i.dms_n && !bus_i.rd_n;
   // A latch like the glue, so row falls a full cycle before column
   always_latch begin
      if (rst_i) row_strobe_n_o = 1'b1;
      else if (sel && bus_i.addr[13:12] == 2'h1) begin
         row_strobe_n_o = 1'b0;
         row_q = bus_i.addr[2:0];
      end else if (sel && bus_i.addr[13:12] == 2'h2) begin
         row_strobe_n_o = 1'b1;
      end
   end // Level holds otherwise
   assign column_strobe_n_o = !(!bus_i.dms_n && bus_i.addr[13:12] == 2'h3
                              && (!bus_i.rd_n || !bus_i.wr_n));
   always_ff @(posedge clk_i) begin
      store_strobe_n_o <= rst_i | bus_i.wr_n;
   end
   always @(negedge store_strobe_n_o) begin
      if (!column_strobe_n_o) mem[{row_q, bus_i.addr[2:0]}] <= data_i;
   end
   // Released data lines toggle so stale data cannot pass for a read
   assign data_o = (!bus_i.rd_n && !column_strobe_n_o) ?
                   mem[{row_q, bus_i.addr[2:0]}] : ~last;
   always_ff @(posedge clk_i) begin
      last <= data_o;
   end
endmodule : dgs_dram_model

// *** verification/test_dgs_host.sv ***
// Self-checking bench for the processor-side DRAM sequencer
module test_dgs_host
   import dgs_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   // Latency counts edges to the answer, occupancy edges until ready again
   typedef struct {
      dgs_req_t          req;
      logic [DATA_W-1:0] exp;
      int                lat;
      int                occ;
   } dgs_case_t;
   dgs_case_t cases [0:7] = '{
      '{'{1'b1, 10'h3, 10'h5, 1'b0, 16'h1234}, 16'h0, 3, 5},
      '{'{1'b1, 10'h2, 10'h5, 1'b0, 16'habcd}, 16'h0, 3, 5},
      '{'{1'b0, 10'h3, 10'h5, 1'b0, 16'h0}, 16'h1234, 3, 5},
      '{'{1'b0, 10'h2, 10'h5, 1'b0, 16'h0}, 16'habcd, 3, 5},
      '{'{1'b1, 10'h1, 10'h7, 1'b1, 16'h5a5a}, 16'h0, 3, 3},
      '{'{1'b0, 10'h1, 10'h7, 1'b1, 16'h0}, 16'h5a5a, 2, 2},
      '{'{1'b1, 10'h4, 10'h2, 1'b0, 16'h0f0f}, 16'h0, 5, 7},
      '{'{1'b0, 10'h4, 10'h2, 1'b0, 16'h0}, 16'h0f0f, 3, 5}};
   logic              clk_i = 1'b0, rst_i = 1'b1, req_valid_i = 1'b0;
   dgs_req_t          req_i = '0;
   logic              req_ready_o, rsp_valid_o, data_oe_o;
   logic [DATA_W-1:0] rsp_data_o, data_o, data_i, wdata;
   dgs_bus_t          bus_o;
   logic [1:0]        wait_cnt;
   logic              row_n, col_n, store_n;
   int                mismatches = 0, num_checks = 0, cycles = 0, lat, occ;
   assign wdata = data_oe_o ? data_o : ~data_o;
   dgs_host dut (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
      .req_i(req_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
      .rsp_data_o(rsp_data_o), .bus_o(bus_o), .data_o(data_o),
      .data_oe_o(data_oe_o), .data_i(data_i),
      .data_wait_count_bank3_o(wait_cnt));
   dgs_dram_model dram (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_o),
      .data_i(wdata), .data_o(data_i), .row_strobe_n_o(row_n),
      .column_strobe_n_o(col_n), .store_strobe_n_o(store_n));
   task automatic check(string name, logic [15:0] exp, logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask : check
   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : tally_and_finish
   task automatic run(dgs_req_t r, output int n, output int m);
      while (!req_ready_o) @(posedge clk_i) #1;
      req_i = r;
      req_valid_i = 1'b1;
      @(posedge clk_i) #1;
      req_valid_i = 1'b0;
      n = 0;
      while (!rsp_valid_o) begin
         @(posedge clk_i) #1;
         n++;
      end
      m = n;
      while (!req_ready_o) begin
         @(posedge clk_i) #1;
         m++;
      end
   endtask : run
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   always @(negedge col_n) begin
      check("row before column", 16'h0, 16'(row_n));
      // Let the registered store strobe settle before looking at it
      #1;
      if (!bus_o.rd_n) check("store in read", 16'h1, 16'(store_n));
   end
   always @(negedge store_n) check("column at store", 16'h0, 16'(col_n));
   always @(posedge clk_i) begin
      cycles++;
      if (!bus_o.dms_n && bus_o.addr >= INT_BOUND) check("addr", 16'h0, 16'h1);
      if (cycles == 3000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (5) @(posedge clk_i);
      #1 rst_i = 1'b0;
      check("row after reset", 16'h1, 16'(row_n));
      check("ready after reset", 16'h1, 16'(req_ready_o));
      check("wait count", 16'h1, 16'(wait_cnt));
      foreach (cases[i]) begin
         run(cases[i].req, lat, occ);
         check("latency", 16'(cases[i].lat), 16'(lat));
         check("occupancy", 16'(cases[i].occ), 16'(occ));
         if (!cases[i].req.write) check("read", cases[i].exp, rsp_data_o);
         check("row level", 16'(!cases[i].req.page), 16'(row_n));
      end
      // Reset in the middle of an access, after the row has opened
      while (!req_ready_o) @(posedge clk_i) #1;
      req_i = cases[0].req;
      req_valid_i = 1'b1;
      @(posedge clk_i) #1 req_valid_i = 1'b0;
      @(posedge clk_i) #1 rst_i = 1'b1;
      @(posedge clk_i) #1 rst_i = 1'b0;
      check("strobes", 16'h7, {13'h0, bus_o.dms_n, bus_o.rd_n, bus_o.wr_n});
      check("store after reset", 16'h1, 16'(store_n));
      run(cases[2].req, lat, occ);
      check("read after reset", 16'h1234, rsp_data_o);
      check("latency after reset", 16'h3, 16'(lat));
      tally_and_finish();
   end
endmodule : test_dgs_host
